/* File: shared/otf_regs.svh */
// register offsets, field positions, reset values and depths of the trim block
`ifndef OTF_REGS_SVH
`define OTF_REGS_SVH
`define OTF_A_BIAS_X 8'h38
`define OTF_A_BIAS_Y 8'h39
`define OTF_A_BIAS_Z 8'h3a
`define OTF_A_SPARE0 8'h3b
`define OTF_A_SPARE1 8'h3c
`define OTF_A_CFG 8'h3e
`define OTF_A_FIFO 8'h3f
`define OTF_CFG_MASK 8'hc3
`define OTF_RST_BYTE 8'h00
`define OTF_MODE_HI 7
`define OTF_MODE_LO 6
`define OTF_SEL_HI 1
`define OTF_SEL_LO 0
`define OTF_BIAS_SHIFT 3'h5
`define OTF_STORE_FRAMES 32
`define OTF_STAGE_WORDS 16
`define OTF_FRAME_BITS 48
`define OTF_LAST_XYZ 3'h5
`define OTF_LAST_ONE 3'h1
`endif

/* File: shared/otf_pkg.sv */
// types shared by the trim and frame buffer block
package otf_pkg;
    typedef logic [2:0][13:0] otf_axes_t;
    typedef enum logic [1:0] {
        OTF_BYPASS = 2'b00,
        OTF_HOLD = 2'b01,
        OTF_STREAM = 2'b10,
        OTF_RSVD = 2'b11
    } otf_mode_t;
    typedef enum logic [1:0] {
        OTF_XYZ = 2'b00,
        OTF_X_ONLY = 2'b01,
        OTF_Y_ONLY = 2'b10,
        OTF_Z_ONLY = 2'b11
    } otf_sel_t;
    typedef struct packed {
        logic [2:0][7:0] bias;
        logic [7:0] spare_byte_one;
        logic [7:0] spare_byte_zero;
    } otf_nvm_t;
    typedef struct packed {
        otf_nvm_t img;
        logic [7:0] cfg;
        logic [7:0] rdata;
        logic [2:0] idx;
        logic burst;
        logic nvm_req;
        otf_axes_t filt;
        otf_axes_t unfilt;
    } otf_st_t;
endpackage : otf_pkg

/* File: hdl/otf_top.sv */
// bias trim, spare nvm bytes and frame buffer register slice
`timescale 1ns/1ps
// Notes on behaviour
// - y bias subtracted from filtered and raw y
// - z bias subtracted from filtered and raw z
// - bias is signed byte, 1/128 g steps
// - bias weight same in every g range
// - bias bytes saved to and restored from nvm
// - bias written by host or fast compensation
// - two spare bytes, nvm backed, read/write
// - config write empties buffer, clears full
// - policy 00: one frame, newest overwrites
// - policy 01: stop storing at 32 frames
// - policy 10: drop oldest when full
// - capture field picks xyz, x, y or z
// - readout bytes use data register layout
// - burst at readout address holds address
// - partly read frame is discarded whole at burst end
// - xyz frame: xl xh yl yh zl zh
// - single axis frame: low then high
// - x bias subtracted from filtered and raw x
// - bias clear zeroes all three bias bytes

module otf_fifo #(
    parameter int W = 48,
    parameter int D = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_clr,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [W-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [W-1:0] o_out_data,
    output logic [$clog2(D+1)-1:0] o_level
);
    localparam int AW = $clog2(D);
    localparam int CW = $clog2(D+1);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [CW-1:0] cnt;
    } otf_fifo_st_t;
    otf_fifo_st_t st_r;
    otf_fifo_st_t st_nxt;
    logic push;
    logic pop;

    // a pop in the same cycle frees the slot, so a full buffer still takes
    assign o_in_ready = (st_r.cnt != CW'(D)) || i_out_ready;
    assign o_out_valid = st_r.cnt != '0;
    assign o_out_data = st_r.mem[st_r.rd];
    assign o_level = st_r.cnt;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb begin
        st_nxt = st_r;
        if (i_clr) begin
            st_nxt.rd = '0;
            st_nxt.wr = '0;
            st_nxt.cnt = '0;
        end else begin
            if (push) begin
                st_nxt.mem[st_r.wr] = i_in_data;
                st_nxt.wr = st_r.wr + AW'(1);
            end
            if (pop) begin
                st_nxt.rd = st_r.rd + AW'(1);
            end
            if (push && !pop) begin
                st_nxt.cnt = st_r.cnt + CW'(1);
            end else if (pop && !push) begin
                st_nxt.cnt = st_r.cnt - CW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else if (i_ce) begin
            st_r <= st_nxt;
        end
    end
endmodule : otf_fifo

module otf_top (
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic I_REG_WR,
    input wire logic [7:0] I_REG_WDATA,
    input wire logic I_REG_RD,
    input wire logic I_BURST_START,
    input wire logic I_BURST_END,
    output logic [7:0] O_REG_RDATA,
    output logic O_ADDR_HOLD,
    input wire otf_pkg::otf_axes_t I_ACC_FILT,
    input wire otf_pkg::otf_axes_t I_ACC_UNFILT,
    input wire logic [1:0] I_RANGE,
    output otf_pkg::otf_axes_t O_ACC_FILT,
    output otf_pkg::otf_axes_t O_ACC_UNFILT,
    input wire logic I_SMP_VALID,
    output logic O_SMP_READY,
    input wire logic I_FC_DONE,
    input wire logic [1:0] I_FC_AXIS,
    input wire logic [7:0] I_FC_VALUE,
    input wire logic I_BIAS_CLR,
    input wire logic I_NVM_LOAD,
    input wire otf_pkg::otf_nvm_t I_NVM_IMAGE,
    output otf_pkg::otf_nvm_t O_NVM_IMAGE,
    output logic O_NVM_REQ,
    output logic [5:0] O_FIFO_LEVEL,
    output logic O_FIFO_FULL
);
    `include "otf_regs.svh"

    otf_pkg::otf_st_t st_r;
    otf_pkg::otf_st_t st_nxt;
    otf_pkg::otf_axes_t corr_f;
    otf_pkg::otf_axes_t corr_u;
    otf_pkg::otf_mode_t mode;
    otf_pkg::otf_sel_t sel;
    logic [`OTF_FRAME_BITS-1:0] frame_in;
    logic [`OTF_FRAME_BITS-1:0] stg_data;
    logic [`OTF_FRAME_BITS-1:0] head;
    logic [4:0] stg_level;
    logic [5:0] level;
    logic stg_valid;
    logic stg_take;
    logic store_valid;
    logic full;
    logic drop;
    logic rd_pop;
    logic cfg_wr;
    logic [2:0] last_idx;

    // bias is 1/128 g; data lsb is 1/4096 g at 2 g and doubles per range
    function automatic logic [13:0] trim(input logic [13:0] raw,
                                         input logic [7:0] b,
                                         input logic [1:0] rng);
        logic [13:0] sb;
        sb = {{6{b[7]}}, b};
        trim = raw - (sb << (`OTF_BIAS_SHIFT - {1'b0, rng}));
    endfunction : trim

    // acceleration register layout: low byte keeps the new data flag in bit 0
    function automatic logic [15:0] fmt(input logic [13:0] d);
        fmt = {d[13:6], d[5:0], 1'b0, 1'b1};
    endfunction : fmt

    function automatic logic [7:0] reg_byte(input logic [7:0] a,
                                            input otf_pkg::otf_st_t s);
        case (a)
            `OTF_A_BIAS_X: reg_byte = s.img.bias[0];
            `OTF_A_BIAS_Y: reg_byte = s.img.bias[1];
            `OTF_A_BIAS_Z: reg_byte = s.img.bias[2];
            `OTF_A_SPARE0: reg_byte = s.img.spare_byte_zero;
            `OTF_A_SPARE1: reg_byte = s.img.spare_byte_one;
            `OTF_A_CFG: reg_byte = s.cfg;
            default: reg_byte = `OTF_RST_BYTE;
        endcase
    endfunction : reg_byte

    for (genvar a = 0; a < 3; a++) begin : g_axis
        assign corr_f[a] = trim(I_ACC_FILT[a], st_r.img.bias[a], I_RANGE);
        assign corr_u[a] = trim(I_ACC_UNFILT[a], st_r.img.bias[a], I_RANGE);
    end

    assign mode = otf_pkg::otf_mode_t'(st_r.cfg[`OTF_MODE_HI:`OTF_MODE_LO]);
    assign sel = otf_pkg::otf_sel_t'(st_r.cfg[`OTF_SEL_HI:`OTF_SEL_LO]);

    always_comb begin
        case (sel)
            otf_pkg::OTF_XYZ:
                frame_in = {fmt(corr_f[2]), fmt(corr_f[1]),
                            fmt(corr_f[0])};
            otf_pkg::OTF_X_ONLY: frame_in = {32'h0, fmt(corr_f[0])};
            otf_pkg::OTF_Y_ONLY: frame_in = {32'h0, fmt(corr_f[1])};
            otf_pkg::OTF_Z_ONLY: frame_in = {32'h0, fmt(corr_f[2])};
            default: frame_in = '0;
        endcase
    end

    assign last_idx = (sel == otf_pkg::OTF_XYZ) ? `OTF_LAST_XYZ
                                                : `OTF_LAST_ONE;
    assign cfg_wr = I_REG_WR && (I_REG_ADDR == `OTF_A_CFG);
    assign full = level == 6'(`OTF_STORE_FRAMES);
    // frames wait in staging while a burst reads, so a frame being read
    // cannot be overwritten under the host; staging then pushes back
    assign stg_take = stg_valid && !st_r.burst && !cfg_wr;
    always_comb begin
        case (mode)
            otf_pkg::OTF_HOLD: drop = 1'b0;
            otf_pkg::OTF_STREAM: drop = stg_take && full;
            default: drop = stg_take && (level != 6'h00);
        endcase
    end

    otf_fifo #(.W(`OTF_FRAME_BITS), .D(`OTF_STAGE_WORDS)) u_stage (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_clr(cfg_wr),
        .i_in_valid(I_SMP_VALID),
        .o_in_ready(O_SMP_READY),
        .i_in_data(frame_in),
        .o_out_valid(stg_valid),
        .i_out_ready(!st_r.burst),
        .o_out_data(stg_data),
        .o_level(stg_level)
    );

    // in hold mode a full store refuses and the staged frame is dropped
    otf_fifo #(.W(`OTF_FRAME_BITS), .D(`OTF_STORE_FRAMES)) u_store (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .i_ce(I_CE),
        .i_clr(cfg_wr),
        .i_in_valid(stg_take && !(mode == otf_pkg::OTF_HOLD && full)),
        .o_in_ready(),
        .i_in_data(stg_data),
        .o_out_valid(store_valid),
        .i_out_ready(rd_pop || drop),
        .o_out_data(head),
        .o_level(level)
    );

    always_comb begin
        st_nxt = st_r;
        rd_pop = 1'b0;
        st_nxt.filt = corr_f;
        st_nxt.unfilt = corr_u;
        if (I_NVM_LOAD) begin
            st_nxt.img = I_NVM_IMAGE;
            st_nxt.nvm_req = 1'b0;
        end
        if (I_REG_WR) begin
            case (I_REG_ADDR)
                `OTF_A_BIAS_X: st_nxt.img.bias[0] = I_REG_WDATA;
                `OTF_A_BIAS_Y: st_nxt.img.bias[1] = I_REG_WDATA;
                `OTF_A_BIAS_Z: st_nxt.img.bias[2] = I_REG_WDATA;
                `OTF_A_SPARE0: st_nxt.img.spare_byte_zero = I_REG_WDATA;
                `OTF_A_SPARE1: st_nxt.img.spare_byte_one = I_REG_WDATA;
                `OTF_A_CFG: begin
                    st_nxt.cfg = I_REG_WDATA & `OTF_CFG_MASK;
                    st_nxt.idx = 3'h0;
                end
                default: ;
            endcase
        end
        // engine result beats a host write in the same cycle
        case (I_FC_AXIS)
            2'b01: if (I_FC_DONE) st_nxt.img.bias[0] = I_FC_VALUE;
            2'b10: if (I_FC_DONE) st_nxt.img.bias[1] = I_FC_VALUE;
            2'b11: if (I_FC_DONE) st_nxt.img.bias[2] = I_FC_VALUE;
            default: ;
        endcase
        if (I_BIAS_CLR) begin
            st_nxt.img.bias = '0;
        end
        if (I_REG_RD) begin
            if (I_REG_ADDR != `OTF_A_FIFO) begin
                st_nxt.rdata = reg_byte(I_REG_ADDR, st_r);
            end else if (store_valid && !cfg_wr) begin
                st_nxt.rdata = head[{st_r.idx, 3'h0} +: 8];
                if (st_r.idx == last_idx) begin
                    rd_pop = 1'b1;
                    st_nxt.idx = 3'h0;
                end else begin
                    st_nxt.idx = st_r.idx + 3'h1;
                end
            end else begin
                st_nxt.rdata = `OTF_RST_BYTE;
            end
        end
        if (I_BURST_START) begin
            st_nxt.burst = I_REG_ADDR == `OTF_A_FIFO;
        end
        if (I_BURST_END) begin
            st_nxt.burst = 1'b0;
            if (st_r.idx != 3'h0 && !cfg_wr) begin
                rd_pop = 1'b1;
                st_nxt.idx = 3'h0;
            end
        end
        if (drop && st_r.idx != 3'h0) begin
            st_nxt.idx = 3'h0;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
            st_r <= '0;
            st_r.nvm_req <= 1'b1;
        end else if (I_CE) begin
            st_r <= st_nxt;
        end
    end

    assign O_REG_RDATA = st_r.rdata;
    assign O_ADDR_HOLD = st_r.burst;
    assign O_ACC_FILT = st_r.filt;
    assign O_ACC_UNFILT = st_r.unfilt;
    assign O_NVM_IMAGE = st_r.img;
    assign O_NVM_REQ = st_r.nvm_req;
    assign O_FIFO_LEVEL = level;
    assign O_FIFO_FULL = full;

    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);

    a_cfg_clears_buf: assert property (
        I_CE && cfg_wr |=> level == 6'h00 && !O_FIFO_FULL)
        else $error("config write did not empty the buffer");
    a_bypass_one_frame: assert property (
        mode == otf_pkg::OTF_BYPASS |-> level <= 6'h01)
        else $error("bypass holds more than one frame");
    a_hold_stays_full: assert property (
        I_CE && mode == otf_pkg::OTF_HOLD && full && !rd_pop && !cfg_wr
        |=> full)
        else $error("hold mode lost a frame without a read");
    a_stream_keeps: assert property (
        I_CE && mode == otf_pkg::OTF_STREAM && full && stg_take && !rd_pop
        |=> full && head == $past(u_store.st_r.mem[u_store.st_r.rd + 5'h1]))
        else $error("stream mode did not drop the oldest frame");
    a_bias_clear_zero: assert property (
        I_CE && I_BIAS_CLR |=> O_NVM_IMAGE.bias == '0)
        else $error("bias clear left a nonzero bias");
    a_fc_updates_y: assert property (
        I_CE && I_FC_DONE && I_FC_AXIS == 2'b10 && !I_BIAS_CLR
        |=> O_NVM_IMAGE.bias[1] == $past(I_FC_VALUE))
        else $error("fast compensation result not taken");
    a_y_trim_out: assert property (
        I_CE |=> O_ACC_FILT[1] == 14'($past(I_ACC_FILT[1])
            - ({{6{$past(st_r.img.bias[1][7])}}, $past(st_r.img.bias[1])}
               << (3'h5 - {1'b0, $past(I_RANGE)}))))
        else $error("y output not trimmed by bias");
    a_empty_read_zero: assert property (
        I_CE && I_REG_RD && I_REG_ADDR == `OTF_A_FIFO && !store_valid
        |=> O_REG_RDATA == 8'h00 && st_r.idx == $past(st_r.idx))
        else $error("empty readout not zero or changed state");
    a_burst_holds: assert property (
        I_CE && I_BURST_START && I_REG_ADDR == `OTF_A_FIFO && !I_BURST_END
        |=> O_ADDR_HOLD)
        else $error("burst at readout did not hold address");
    a_partial_drops: assert property (
        I_CE && I_BURST_END && st_r.idx != 3'h0 && !cfg_wr && !stg_take
        |=> st_r.idx == 3'h0 && level == $past(level) - 6'h01)
        else $error("partly read frame was kept");

    c_full_hold: cover property (mode == otf_pkg::OTF_HOLD && full);
    c_xyz_frame: cover property (
        rd_pop && sel == otf_pkg::OTF_XYZ && st_r.burst);
    c_partial: cover property (I_BURST_END && st_r.idx != 3'h0);
    c_stage_full: cover property (stg_level == 5'h10);
endmodule : otf_top

/* File: test/otf_host_model.sv */
// host model driving the register strobes and read bursts
`timescale 1ns/1ps
`include "otf_regs.svh"
module otf_host_model (
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    input wire logic i_hold,
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd,
    output logic o_bs,
    output logic o_be
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
        o_bs = 1'b0;
        o_be = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        // the reserved policy code never leaves the host
        if (a == `OTF_A_CFG && v[7:6] == 2'b11) v[7:6] = 2'b00;
        @(posedge i_clk);
        o_addr <= a;
        o_wr <= 1'b1;
        o_wdata <= v;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // a released data bus must not echo the last byte
        o_wdata <= ~v;
    endtask : wr_reg
    task automatic xfer(input logic [7:0] a, input int n, input logic st,
                        output logic [7:0] q[$], output logic h);
        q = {};
        h = 1'b0;
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        o_bs <= st;
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            o_bs <= 1'b0;
            o_rd <= (i < n - 1);
            #1 q.push_back(i_rdata);
            if (i == 0) h = i_hold;
        end
        if (st) begin
            @(posedge i_clk);
            o_be <= 1'b1;
            @(posedge i_clk);
            o_be <= 1'b0;
        end
    endtask : xfer
endmodule : otf_host_model

/* File: test/tb_top.sv */
// self-checking bench for the trim and frame buffer slice
`timescale 1ns/1ps
module tb_top;
    logic clk, rst_n, ce, wr, rd, bs, be, sv, fcd, bclr, nload;
    logic hold, nreq, srdy, full;
    logic [7:0] addr, wdata, fcv, rdata;
    logic [1:0] rng, fca;
    logic [5:0] lvl;
    otf_pkg::otf_axes_t af, au, of, ou;
    otf_pkg::otf_nvm_t ni, nvo;
    logic [7:0] q[$];
    int error_cnt = 0;
    int checked = 0;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    otf_top i_dut (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce),
        .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_WDATA(wdata),
        .I_REG_RD(rd), .I_BURST_START(bs), .I_BURST_END(be),
        .O_REG_RDATA(rdata), .O_ADDR_HOLD(hold), .I_ACC_FILT(af),
        .I_ACC_UNFILT(au), .I_RANGE(rng), .O_ACC_FILT(of),
        .O_ACC_UNFILT(ou), .I_SMP_VALID(sv), .O_SMP_READY(srdy),
        .I_FC_DONE(fcd), .I_FC_AXIS(fca), .I_FC_VALUE(fcv),
        .I_BIAS_CLR(bclr), .I_NVM_LOAD(nload), .I_NVM_IMAGE(ni),
        .O_NVM_IMAGE(nvo), .O_NVM_REQ(nreq), .O_FIFO_LEVEL(lvl),
        .O_FIFO_FULL(full)
    );
    otf_host_model i_host (
        .i_clk(clk), .i_rdata(rdata), .i_hold(hold), .o_addr(addr),
        .o_wr(wr), .o_wdata(wdata), .o_rd(rd), .o_bs(bs), .o_be(be)
    );

    task automatic give_verdict;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    task automatic chk_b(input logic [7:0] g, e, input string m);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk_b
    task automatic chk_ax(input otf_pkg::otf_axes_t g, e, input string m);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk_ax
    // one distinct value per axis so a swapped axis shows up
    function automatic otf_pkg::otf_axes_t fk(input int k);
        logic [13:0] v;
        v = 14'(k);
        return {v | 14'h2000, v | 14'h1000, v};
    endfunction : fk
    function automatic otf_pkg::otf_axes_t trim(otf_pkg::otf_axes_t a,
                                                 logic [23:0] b, logic [1:0] r);
        logic [13:0] s;
        for (int i = 0; i < 3; i++) begin
            s = {{6{b[8*i+7]}}, b[8*i+:8]};
            trim[i] = a[i] - (s << (3'd5 - 3'(r)));
        end
    endfunction : trim
    task automatic rd1(input logic [7:0] a, input logic [7:0] e);
        logic h0;
        i_host.xfer(a, 1, 1'b0, q, h0);
        chk_b(q[0], e, "register read");
    endtask : rd1
    task automatic push(input int k);
        int w;
        w = 0;
        @(posedge clk);
        af <= fk(k);
        au <= ~fk(k);
        sv <= 1'b1;
        // valid stands until an edge at which ready is high
        #1;
        while (srdy !== 1'b1) begin
            w++;
            if (w > 50) begin
                error_cnt++;
                give_verdict;
            end
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        sv <= 1'b0;
    endtask : push
    task automatic lv(input logic [5:0] e, input logic f);
        repeat (4) @(posedge clk);
        #1;
        chk_b({2'b00, lvl}, {2'b00, e}, "level");
        chk_b({7'h00, full}, {7'h00, f}, "full");
    endtask : lv
    task automatic rdf(input int n, input otf_pkg::otf_axes_t f0, f1,
                       input logic [1:0] s);
        logic [7:0] e[6];
        logic [13:0] v;
        logic h;
        for (int i = 0; i < 6; i++) begin
            v = (s == 2'd0) ? f0[i/2] : (i < 2 ? f0[s-1] : f1[s-1]);
            e[i] = (i % 2) ? v[13:6] : {v[5:0], 2'b01};
        end
        i_host.xfer(8'h3f, n, 1'b1, q, h);
        chk_b({7'h00, h}, 8'h01, "address hold");
        for (int i = 0; i < n; i++) chk_b(q[i], e[i], "frame byte");
        #1;
        chk_b({7'h00, hold}, 8'h00, "hold released");
    endtask : rdf

    initial begin
        logic [7:0] ra[7] = '{8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e};
        logic [7:0] wd[7] = '{8'h80, 8'h7f, 8'h01, 8'hc3, 8'h3c, 8'h77, 8'hbf};
        logic [7:0] ex[7] = '{8'h80, 8'h7f, 8'h01, 8'hc3, 8'h3c, 8'h00, 8'h83};
        logic [7:0] ld[5] = '{8'h44, 8'h22, 8'h33, 8'h55, 8'h66};
        rst_n = 1'b0;
        ce = 1'b1;
        sv = 1'b0;
        fcd = 1'b0;
        bclr = 1'b0;
        nload = 1'b0;
        fcv = 8'h00;
        fca = 2'd0;
        rng = 2'd0;
        af = '0;
        au = '0;
        ni = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk_b({7'h00, nreq}, 8'h01, "nvm request");
        foreach (ra[i]) rd1(ra[i], 8'h00);
        $display("test reset done");
        foreach (ra[i]) i_host.wr_reg(ra[i], wd[i]);
        i_host.wr_reg(8'h3f, 8'h55);
        foreach (ra[i]) rd1(ra[i], ex[i]);
        chk_b(nvo.bias[1], 8'h7f, "nvm image");
        chk_b(nvo.spare_byte_zero, 8'hc3, "nvm spare");
        rd1(8'h3f, 8'h00);
        lv(6'd0, 1'b0);
        $display("test access done");
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            rng <= 2'(r);
            af <= fk(r + 300);
            au <= ~fk(r);
            repeat (3) @(posedge clk);
            #1;
            chk_ax(of, trim(af, 24'h017f80, rng), "filt");
            chk_ax(ou, trim(au, 24'h017f80, rng), "raw");
        end
        $display("test trim done");
        for (int a = 1; a < 4; a++) begin
            @(posedge clk);
            fca <= 2'(a);
            fcv <= 8'(8'h10 + a);
            fcd <= 1'b1;
            @(posedge clk);
            fcd <= 1'b0;
            rd1(8'(8'h37 + a), 8'(8'h10 + a));
        end
        @(posedge clk);
        ni <= {8'h33, 8'h22, 8'h44, 8'h66, 8'h55};
        nload <= 1'b1;
        @(posedge clk);
        nload <= 1'b0;
        for (int i = 0; i < 5; i++) rd1(ra[i], ld[i]);
        chk_b({7'h00, nreq}, 8'h00, "nvm request");
        @(posedge clk);
        bclr <= 1'b1;
        @(posedge clk);
        bclr <= 1'b0;
        for (int i = 0; i < 4; i++) rd1(ra[i], i < 3 ? 8'h00 : 8'h55);
        // a write while the enable is low must leave the byte alone
        @(posedge clk);
        ce <= 1'b0;
        i_host.wr_reg(8'h3c, 8'ha5);
        @(posedge clk);
        ce <= 1'b1;
        rd1(8'h3c, 8'h66);
        $display("test sources done");
        i_host.wr_reg(8'h3e, 8'h40);
        for (int k = 0; k < 34; k++) push(k);
        lv(6'd32, 1'b1);
        rdf(6, fk(0), fk(1), 2'd0);
        lv(6'd31, 1'b0);
        rdf(2, fk(1), fk(2), 2'd0);
        rdf(6, fk(2), fk(3), 2'd0);
        lv(6'd29, 1'b0);
        i_host.wr_reg(8'h3e, 8'h80);
        lv(6'd0, 1'b0);
        chk_b({7'h00, srdy}, 8'h01, "sample ready");
        for (int k = 0; k < 34; k++) push(k);
        lv(6'd32, 1'b1);
        rdf(6, fk(2), fk(3), 2'd0);
        i_host.wr_reg(8'h3e, 8'h00);
        push(5);
        push(6);
        lv(6'd1, 1'b0);
        rdf(6, fk(6), fk(7), 2'd0);
        for (int s = 1; s < 4; s++) begin
            i_host.wr_reg(8'h3e, {6'h10, 2'(s)});
            push(7);
            push(8);
            rdf(4, fk(7), fk(8), 2'(s));
            lv(6'd0, 1'b0);
        end
        rd1(8'h3f, 8'h00);
        $display("test buffer done");
        // soft reset in mid run: request for a reload and bytes back at zero
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk_b({7'h00, nreq}, 8'h01, "nvm request");
        chk_b({7'h00, srdy}, 8'h01, "sample ready");
        rd1(8'h3b, 8'h00);
        $display("test soft reset done");
        give_verdict;
    end
endmodule : tb_top
